/* verilog/uabt_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of
 * the serial port and its auxiliary baud timer.
 * Assumes an 8-bit special function register space with byte addresses.
 */
`ifndef UABT_MAP_SVH
`define UABT_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define UABT_ADDR_POWER_AND_BAUD_CONTROL 8'h87
`define UABT_ADDR_OPTION 8'h94
`define UABT_ADDR_SCTL 8'h98
`define UABT_ADDR_SDATA 8'h99
`define UABT_ADDR_ACTL 8'hC8
`define UABT_ADDR_RLD_LO 8'hCA
`define UABT_ADDR_RLD_HI 8'hCB
`define UABT_ADDR_CNT_LO 8'hCC
`define UABT_ADDR_CNT_HI 8'hCD

// ****************************************
// Field positions
// ****************************************
`define UABT_PC_DOUBLER 7
`define UABT_OPT_ONE_WIRE 7
`define UABT_SC_MP_FILTER 5
`define UABT_SC_RX_EN 4
`define UABT_SC_TX_NINTH 3
`define UABT_SC_RX_NINTH 2
`define UABT_SC_TX_DONE 1
`define UABT_SC_RX_DONE 0
`define UABT_AC_OVF_FLAG 7
`define UABT_AC_EDGE_FLAG 6
`define UABT_AC_RX_BAUD 5
`define UABT_AC_TX_BAUD 4
`define UABT_AC_EXT_EN 3
`define UABT_AC_RUN 2
`define UABT_AC_COUNTER 1
`define UABT_AC_CAPTURE 0

// ****************************************
// Reset values and timing counts
// ****************************************
`define UABT_RST_BYTE 8'h00
`define UABT_TICK_LAST 4'hF
`define UABT_SAMPLE_TICK 4'h7
`define UABT_M2_DIV_LAST 2'h3
`define UABT_AUX_MAX 16'hFFFF
`define UABT_SHIFT_BITS 4'h8
`define UABT_BITS_8 4'h8
`define UABT_BITS_9 4'h9
`define UABT_FRAME_8 4'hA
`define UABT_FRAME_9 4'hB

`endif

/* verilog/uabt_pkg.sv */
/*
 * Types of the serial port with auxiliary baud timer.
 * Assumes uabt_map.svh for all numeric constants.
 */
package uabt_pkg;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [1:0] {
    UABT_MODE_SHIFT = 2'b00,
    UABT_MODE_VAR8 = 2'b01,
    UABT_MODE_FIX9 = 2'b10,
    UABT_MODE_VAR9 = 2'b11
  } uabt_mode_e;

  typedef enum logic [1:0] {
    UABT_TX_IDLE = 2'b00,
    UABT_TX_SHIFT = 2'b01
  } uabt_tx_e;

  typedef enum logic [1:0] {
    UABT_RX_IDLE = 2'b00,
    UABT_RX_START = 2'b01,
    UABT_RX_DATA = 2'b11
  } uabt_rx_e;

  // ****************************************
  // Register access request
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uabt_sfr_s;

  // ****************************************
  // Whole state of the block
  // ****************************************
  typedef struct packed {
    logic rxd_s1;
    logic rxd_s2;
    logic line_s1;
    logic line_s2;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_d;
    logic trg_s1;
    logic trg_s2;
    logic trg_d;
    logic doubler;
    logic [3:0] power_and_baud_control_low;
    logic [7:0] option;
    logic [7:0] sctl;
    logic [7:0] rx_buf;
    logic [7:0] actl;
    logic [15:0] reload;
    logic [15:0] count;
    logic aux_phase;
    logic main_half;
    logic [1:0] m2_div;
    logic sh_phase;
    uabt_tx_e tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_cnt;
    uabt_rx_e rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_cnt;
    logic [7:0] rdata;
    logic txd_n;
    logic line_out;
    logic line_oe;
    logic sclk_n;
  } uabt_state_s;

endpackage

/* verilog/uabt_core.sv */
/*
 * Serial port with shift, 8-bit and 9-bit frames, single-wire option,
 * and the 16-bit auxiliary timer that can supply its bit clock.
 * Assumes a same-clock register port and a main timer overflow pulse
 * on the same clock; all pins are asynchronous and are synchronised.
 */
`include "uabt_map.svh"

// Behaviour
// - Receive bit clock comes from aux overflow when rx select set.
// - Transmit bit clock comes from aux overflow when tx select set.
// - Any baud select forces aux auto-reload on overflow.
// - Trigger falling edge acts only with enable and no baud select.
// - Aux counter counts only while run bit is set.
// - Timer mode counts every 2 clocks; counter mode on pin falls.
// - Reload mode loads reload pair on overflow or trigger edge.
// - Capture mode copies count into reload pair on trigger edge.
// - Single-wire mode shares one pin for transmit and receive.
// - Mode 00 is 8-bit shift register at half clock rate.
// - Mode 01 is 8-bit frame clocked by timer overflow.
// - Mode 10 is 9-bit frame at clock over 64, or 32.
// - Mode 11 is 9-bit frame clocked by timer overflow.
// - 9-bit modes with filter drop frames whose ninth bit is 0.
// - 8-bit timer mode with filter needs a valid stop bit.
// - Ninth bit sent from register; ninth or stop bit stored.
// - Transmit done set after bit 8 or at stop start.
// - Receive done set after bit 8 or at stop sample.
// - Data write starts sending; read gives separate receive buffer.
// - Main timer source gives bit every 32 or 16 overflows.
// - Aux source gives one bit per 16 aux overflows.
// - Doubler doubles main-timer-clocked and fixed 9-bit rates; aux-clocked rates are not doubled.
module uabt_core (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input uabt_pkg::uabt_sfr_s i_sfr,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_main_timer_ovf,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_line_in,
  output logic o_line_out,
  output logic o_line_oe,
  output logic o_shift_clock,
  input wire logic i_count_pin,
  input wire logic i_trigger_pin
);

  uabt_pkg::uabt_state_s s;
  uabt_pkg::uabt_state_s n;

  logic [1:0] mode;
  logic mode0;
  logic nine;
  logic baud_aux;
  logic aux_inc;
  logic aux_ovf;
  logic ext_hit;
  logic main_tick;
  logic m2_tick;
  logic rx_tick;
  logic tx_tick;
  logic rx_line;
  logic rx_samp;
  logic rx_stop;
  logic rx_ninth;
  logic rx_accept;
  logic m0_rx_done;
  logic [8:0] rx_sh_in;
  logic tx_adv;
  logic [3:0] tx_bits_n;
  logic [3:0] tx_total;
  logic wr_actl;
  logic wr_count;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic tick16(input logic [1:0] md, input logic sel,
                                  input logic aux_o, input logic main_t,
                                  input logic m2_t);
    if (md == uabt_pkg::UABT_MODE_FIX9) begin
      tick16 = m2_t;
    end else if (sel) begin
      tick16 = aux_o;
    end else begin
      tick16 = main_t;
    end
  endfunction

  function automatic logic [8:0] shift_in(input logic [8:0] sh,
                                          input logic b);
    shift_in = {b, sh[8:1]};
  endfunction

  // ****************************************
  // Decoded events
  // ****************************************
  assign mode = s.sctl[7:6];
  assign mode0 = (mode == uabt_pkg::UABT_MODE_SHIFT);
  assign nine = mode[1];
  assign baud_aux = s.actl[`UABT_AC_RX_BAUD] | s.actl[`UABT_AC_TX_BAUD];
  assign aux_inc = s.actl[`UABT_AC_RUN] & (s.actl[`UABT_AC_COUNTER] ?
                   (s.cnt_d & ~s.cnt_s2) : s.aux_phase);
  assign aux_ovf = aux_inc & (s.count == `UABT_AUX_MAX);
  assign ext_hit = s.trg_d & ~s.trg_s2 & s.actl[`UABT_AC_EXT_EN] &
                   ~baud_aux;
  assign main_tick = i_main_timer_ovf & (s.doubler | s.main_half);
  assign m2_tick = s.doubler ? s.m2_div[0] :
                   (s.m2_div == `UABT_M2_DIV_LAST);
  assign rx_tick = tick16(mode, s.actl[`UABT_AC_RX_BAUD], aux_ovf,
                          main_tick, m2_tick);
  assign tx_tick = tick16(mode, s.actl[`UABT_AC_TX_BAUD], aux_ovf,
                          main_tick, m2_tick);
  assign rx_line = s.option[`UABT_OPT_ONE_WIRE] ? s.line_s2 : s.rxd_s2;
  assign rx_sh_in = shift_in(s.rx_shift, rx_line);
  assign rx_samp = (s.rx_state == uabt_pkg::UABT_RX_DATA) & ~mode0 &
                   rx_tick & (s.rx_cnt == `UABT_SAMPLE_TICK);
  assign rx_stop = rx_samp &
                   (s.rx_bits == (nine ? `UABT_BITS_9 : `UABT_BITS_8));
  assign rx_ninth = nine ? s.rx_shift[8] : rx_line;
  assign rx_accept = rx_stop & ~s.sctl[`UABT_SC_RX_DONE] &
                     (~s.sctl[`UABT_SC_MP_FILTER] | rx_ninth);
  assign m0_rx_done = (s.rx_state == uabt_pkg::UABT_RX_DATA) & mode0 &
                      s.sh_phase & (s.rx_bits == `UABT_SHIFT_BITS - 4'h1);
  assign tx_adv = (s.tx_state == uabt_pkg::UABT_TX_SHIFT) & (mode0 ?
                  s.sh_phase : (tx_tick & (s.tx_cnt == `UABT_TICK_LAST)));
  assign tx_bits_n = s.tx_bits + 4'h1;
  assign tx_total = mode0 ? `UABT_SHIFT_BITS :
                    (nine ? `UABT_FRAME_9 : `UABT_FRAME_8);
  assign wr_actl = i_sfr.wr & (i_sfr.addr == `UABT_ADDR_ACTL);
  assign wr_count = i_sfr.wr & ((i_sfr.addr == `UABT_ADDR_CNT_LO) |
                                (i_sfr.addr == `UABT_ADDR_CNT_HI));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    n = s;
    n.rxd_s1 = i_rxd;
    n.rxd_s2 = s.rxd_s1;
    n.line_s1 = i_line_in;
    n.line_s2 = s.line_s1;
    n.cnt_s1 = i_count_pin;
    n.cnt_s2 = s.cnt_s1;
    n.cnt_d = s.cnt_s2;
    n.trg_s1 = i_trigger_pin;
    n.trg_s2 = s.trg_s1;
    n.trg_d = s.trg_s2;
    n.m2_div = s.m2_div + 2'h1;
    n.sh_phase = ~s.sh_phase;
    if (i_main_timer_ovf) begin
      n.main_half = ~s.main_half;
    end
    // Auxiliary timer
    if (s.actl[`UABT_AC_RUN]) begin
      n.aux_phase = ~s.aux_phase;
    end
    if (aux_inc) begin
      n.count = s.count + 16'h0001;
    end
    if (aux_ovf & (baud_aux | ~s.actl[`UABT_AC_CAPTURE])) begin
      n.count = s.reload;
    end
    if (ext_hit & ~s.actl[`UABT_AC_CAPTURE]) begin
      n.count = s.reload;
    end
    if (ext_hit & s.actl[`UABT_AC_CAPTURE]) begin
      n.reload = s.count;
    end
    // Transmitter
    if (tx_adv) begin
      n.tx_shift = {1'b1, s.tx_shift[10:1]};
      n.tx_bits = tx_bits_n;
      if (mode0 ? (tx_bits_n == tx_total) :
          (tx_bits_n == tx_total - 4'h1)) begin
        n.sctl[`UABT_SC_TX_DONE] = 1'b1;
      end
      if (tx_bits_n == tx_total) begin
        n.tx_state = uabt_pkg::UABT_TX_IDLE;
      end
    end
    if ((s.tx_state == uabt_pkg::UABT_TX_SHIFT) & ~mode0 & tx_tick) begin
      n.tx_cnt = s.tx_cnt + 4'h1;
    end
    // Receiver
    if ((s.rx_state != uabt_pkg::UABT_RX_IDLE) & ~mode0 & rx_tick) begin
      n.rx_cnt = s.rx_cnt + 4'h1;
    end
    case (s.rx_state)
      uabt_pkg::UABT_RX_IDLE: begin
        if (s.sctl[`UABT_SC_RX_EN] & mode0 &
            ~s.sctl[`UABT_SC_RX_DONE]) begin
          n.rx_state = uabt_pkg::UABT_RX_DATA;
          n.rx_bits = 4'h0;
        end else if (s.sctl[`UABT_SC_RX_EN] & ~mode0 & ~rx_line) begin
          n.rx_state = uabt_pkg::UABT_RX_START;
          n.rx_cnt = 4'h0;
        end
      end
      uabt_pkg::UABT_RX_START: begin
        if (rx_tick & (s.rx_cnt == `UABT_SAMPLE_TICK)) begin
          n.rx_bits = 4'h0;
          n.rx_state = rx_line ? uabt_pkg::UABT_RX_IDLE :
                       uabt_pkg::UABT_RX_DATA;
        end
      end
      uabt_pkg::UABT_RX_DATA: begin
        if (mode0 & s.sh_phase) begin
          n.rx_shift = rx_sh_in;
          n.rx_bits = s.rx_bits + 4'h1;
          if (m0_rx_done) begin
            n.rx_buf = rx_sh_in[8:1];
            n.sctl[`UABT_SC_RX_DONE] = 1'b1;
            n.rx_state = uabt_pkg::UABT_RX_IDLE;
          end
        end else if (rx_stop) begin
          n.rx_state = uabt_pkg::UABT_RX_IDLE;
          if (rx_accept) begin
            n.rx_buf = nine ? s.rx_shift[7:0] : s.rx_shift[8:1];
            n.sctl[`UABT_SC_RX_NINTH] = rx_ninth;
            n.sctl[`UABT_SC_RX_DONE] = 1'b1;
          end
        end else if (rx_samp) begin
          n.rx_shift = rx_sh_in;
          n.rx_bits = s.rx_bits + 4'h1;
        end
      end
      default: begin
        n.rx_state = uabt_pkg::UABT_RX_IDLE;
      end
    endcase
    if (~s.sctl[`UABT_SC_RX_EN]) begin
      n.rx_state = uabt_pkg::UABT_RX_IDLE;
    end
    // Register writes
    if (i_sfr.wr) begin
      case (i_sfr.addr)
        `UABT_ADDR_POWER_AND_BAUD_CONTROL: begin
          n.doubler = i_sfr.wdata[`UABT_PC_DOUBLER];
          n.power_and_baud_control_low = i_sfr.wdata[3:0];
        end
        `UABT_ADDR_OPTION: begin
          n.option = i_sfr.wdata;
        end
        `UABT_ADDR_SCTL: begin
          n.sctl = i_sfr.wdata;
        end
        `UABT_ADDR_SDATA: begin
          n.tx_state = uabt_pkg::UABT_TX_SHIFT;
          n.tx_bits = 4'h0;
          n.tx_cnt = 4'h0;
          n.sh_phase = 1'b0;
          n.tx_shift = mode0 ? {3'b111, i_sfr.wdata} :
                       {1'b1, (nine ? s.sctl[`UABT_SC_TX_NINTH] : 1'b1),
                        i_sfr.wdata, 1'b0};
        end
        `UABT_ADDR_ACTL: begin
          n.actl = i_sfr.wdata;
        end
        `UABT_ADDR_RLD_LO: begin
          n.reload[7:0] = i_sfr.wdata;
        end
        `UABT_ADDR_RLD_HI: begin
          n.reload[15:8] = i_sfr.wdata;
        end
        `UABT_ADDR_CNT_LO: begin
          n.count[7:0] = i_sfr.wdata;
        end
        `UABT_ADDR_CNT_HI: begin
          n.count[15:8] = i_sfr.wdata;
        end
        default: begin
        end
      endcase
    end
    // Hardware flag sets win over a clearing write
    if (tx_adv & (mode0 ? (tx_bits_n == tx_total) :
        (tx_bits_n == tx_total - 4'h1))) begin
      n.sctl[`UABT_SC_TX_DONE] = 1'b1;
    end
    if (rx_accept | m0_rx_done) begin
      n.sctl[`UABT_SC_RX_DONE] = 1'b1;
    end
    if (aux_ovf & ~baud_aux) begin
      n.actl[`UABT_AC_OVF_FLAG] = 1'b1;
    end
    if (ext_hit) begin
      n.actl[`UABT_AC_EDGE_FLAG] = 1'b1;
    end
    // Register reads
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        `UABT_ADDR_POWER_AND_BAUD_CONTROL: n.rdata = {s.doubler, 3'b000, s.power_and_baud_control_low};
        `UABT_ADDR_OPTION: n.rdata = s.option;
        `UABT_ADDR_SCTL: n.rdata = s.sctl;
        `UABT_ADDR_SDATA: n.rdata = s.rx_buf;
        `UABT_ADDR_ACTL: n.rdata = s.actl;
        `UABT_ADDR_RLD_LO: n.rdata = s.reload[7:0];
        `UABT_ADDR_RLD_HI: n.rdata = s.reload[15:8];
        `UABT_ADDR_CNT_LO: n.rdata = s.count[7:0];
        `UABT_ADDR_CNT_HI: n.rdata = s.count[15:8];
        default: n.rdata = `UABT_RST_BYTE;
      endcase
    end
    // Pin drive
    n.line_oe = n.option[`UABT_OPT_ONE_WIRE] &
                (n.tx_state == uabt_pkg::UABT_TX_SHIFT);
    n.line_out = n.line_oe & n.tx_shift[0];
    n.txd_n = ~n.option[`UABT_OPT_ONE_WIRE] &
              (n.tx_state == uabt_pkg::UABT_TX_SHIFT) & ~n.tx_shift[0];
    n.sclk_n = mode0 & ~n.sh_phase &
               ((n.tx_state == uabt_pkg::UABT_TX_SHIFT) |
                (n.rx_state == uabt_pkg::UABT_RX_DATA));
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_sfr_rdata = s.rdata;
  assign o_txd = ~s.txd_n;
  assign o_line_out = s.line_out;
  assign o_line_oe = s.line_oe;
  assign o_shift_clock = ~s.sclk_n;

  // ****************************************
  // Assertions
  // ****************************************
  a_aux_reload_ovf: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    aux_ovf && baud_aux && !wr_count |=> s.count == $past(s.reload))
    else $error("aux reload on overflow missed");

  a_aux_hold_stop: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !s.actl[`UABT_AC_RUN] && !wr_count && !ext_hit |=> $stable(s.count))
    else $error("aux counter moved while stopped");

  a_aux_timer_rate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    aux_inc && !s.actl[`UABT_AC_COUNTER] && !wr_actl |=> !aux_inc)
    else $error("aux timer counted on adjacent clocks");

  a_aux_capture: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    ext_hit && s.actl[`UABT_AC_CAPTURE] && !i_sfr.wr
    |=> s.reload == $past(s.count))
    else $error("capture did not copy count");

  a_ovf_flag_set: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    aux_ovf && !baud_aux |=> s.actl[`UABT_AC_OVF_FLAG])
    else $error("overflow flag not set");

  a_fix9_tick_gap: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    m2_tick && !s.doubler && !(i_sfr.wr && i_sfr.addr == `UABT_ADDR_POWER_AND_BAUD_CONTROL)
    |=> (!m2_tick || s.doubler) [*3])
    else $error("fixed-rate tick faster than one in four");

  a_rx_filter_drop: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    rx_stop && nine && s.sctl[`UABT_SC_MP_FILTER] && !rx_ninth
    |-> !rx_accept)
    else $error("filtered frame accepted");

  a_tx_start_write: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    i_sfr.wr && i_sfr.addr == `UABT_ADDR_SDATA
    |=> s.tx_state == uabt_pkg::UABT_TX_SHIFT && (mode0 ||
        (s.option[`UABT_OPT_ONE_WIRE] ? o_line_oe && !o_line_out :
         !o_txd)))
    else $error("data write did not start transmission");

  a_one_wire_oe: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    o_line_oe |-> s.option[`UABT_OPT_ONE_WIRE] && o_txd)
    else $error("shared pin driven outside single-wire mode");

  a_rx_enable_gate: assert property (
    @(posedge i_clock) disable iff (!i_reset_n)
    !s.sctl[`UABT_SC_RX_EN] |=> s.rx_state == uabt_pkg::UABT_RX_IDLE)
    else $error("receiver active while disabled");

endmodule

/* verification/uabt_peer.sv */
/*
 * Remote serial peer: sends and receives asynchronous frames.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
module uabt_peer (
  input wire logic i_clock,
  input wire logic i_line,
  output logic o_drive
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Frame sender, line idles high
  // ****
  initial o_drive = 1'b1;

  task automatic send(input int per, input int n, input logic [8:0] d,
                      input logic stp);
    o_drive <= 1'b0;
    repeat (per) @(posedge i_clock);
    for (int i = 0; i < n; i++) begin
      o_drive <= d[i];
      repeat (per) @(posedge i_clock);
    end
    o_drive <= stp;
    repeat (per) @(posedge i_clock);
    o_drive <= 1'b1;
  endtask

  // ****
  // Frame receiver, samples mid bit
  // ****
  task automatic recv(input int per, input int n, output logic [8:0] d,
                      output logic ok);
    int t;
    d = '0;
    t = 0;
    while (i_line !== 1'b0 && t < 4000) begin
      @(posedge i_clock);
      t++;
    end
    repeat (per / 2) @(posedge i_clock);
    ok = (t < 4000) && (i_line === 1'b0);
    for (int i = 0; i < n; i++) begin
      repeat (per) @(posedge i_clock);
      d[i] = i_line;
    end
    repeat (per) @(posedge i_clock);
    ok = ok && (i_line === 1'b1);
  endtask
endmodule

/* verification/uabt_core_test.sv */
/*
 * Self-checking bench of the serial port and aux baud timer.
 * Assumes uabt_core, uabt_peer and the map header on the compile path.
 */
`include "uabt_map.svh"
module uabt_core_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ****
  // Signals and case table
  // ****
  typedef struct packed {
    logic rx;
    logic ow;
    logic [7:0] sc;
    logic [7:0] pc;
    logic [7:0] ac;
    logic stp;
    logic d8;
  } uabt_case_s;

  logic i_clock = 1'b0;
  logic i_reset_n = 1'b0;
  uabt_pkg::uabt_sfr_s sfr = '0;
  logic ovf = 1'b1;
  logic cnt_pin = 1'b1;
  logic trg_pin = 1'b1;
  logic one_w = 1'b0;
  logic [7:0] rdata;
  logic txd, lout, loe, sclk, pd;
  wire logic line = loe ? lout : pd;
  int seed = 62;
  int bad_count = 0;
  int samples_checked = 0;
  logic [8:0] q[$];
  logic [7:0] ra [9] = '{`UABT_ADDR_POWER_AND_BAUD_CONTROL, `UABT_ADDR_OPTION,
    `UABT_ADDR_SCTL, `UABT_ADDR_ACTL, `UABT_ADDR_RLD_LO, `UABT_ADDR_RLD_HI,
    `UABT_ADDR_CNT_LO, `UABT_ADDR_CNT_HI, 8'h00};
  uabt_case_s cs [13] = '{
    '{1'b0, 1'b0, 8'h40, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b0, 1'b0, 8'h40, 8'h00, 8'h00, 1'b1, 1'b0},
    '{1'b0, 1'b0, 8'h80, 8'h80, 8'h00, 1'b1, 1'b1},
    '{1'b0, 1'b0, 8'hC0, 8'h80, 8'h15, 1'b1, 1'b1},
    '{1'b0, 1'b1, 8'h40, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'h50, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'h40, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'h70, 8'h80, 8'h00, 1'b0, 1'b0},
    '{1'b1, 1'b0, 8'h70, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'hF0, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'hF0, 8'h80, 8'h00, 1'b1, 1'b1},
    '{1'b1, 1'b1, 8'h50, 8'h80, 8'h00, 1'b1, 1'b0},
    '{1'b1, 1'b0, 8'hD0, 8'h00, 8'h24, 1'b1, 1'b1}};

  always #2 i_clock = ~i_clock;

  uabt_core dut (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_sfr(sfr),
    .o_sfr_rdata(rdata),
    .i_main_timer_ovf(ovf),
    .i_rxd(one_w ? 1'b1 : pd),
    .o_txd(txd),
    .i_line_in(line),
    .o_line_out(lout),
    .o_line_oe(loe),
    .o_shift_clock(sclk),
    .i_count_pin(cnt_pin),
    .i_trigger_pin(trg_pin)
  );

  uabt_peer peer (
    .i_clock(i_clock),
    .i_line(one_w ? line : txd),
    .o_drive(pd)
  );

  // ****
  // Register access and checks
  // ****
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    sfr <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock);
    sfr <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    sfr.rd <= 1'b0;
    @(posedge i_clock);
    #1 d = rdata;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic ok(input logic c);
    chk(16'(c), 16'h0001);
  endtask

  task test_done();
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****
  // Bit period model
  // ****
  function automatic int exp_per(input uabt_case_s c, input logic [7:0] rl);
    if (c.sc[7:6] == 2'b10) return c.pc[7] ? 32 : 64;
    if (c.rx ? c.ac[5] : c.ac[4]) return 32 * (65536 - int'({8'hFF, rl}));
    return c.pc[7] ? 16 : 32;
  endfunction

  task automatic run_case(input uabt_case_s c);
    logic [8:0] d;
    logic [8:0] got;
    logic okf;
    logic [7:0] r;
    logic [7:0] r2;
    logic [7:0] rl;
    int per;
    int n;
    logic acc;
    rl = c.ac[5] ? 8'hFD : 8'hFE;
    per = exp_per(c, rl);
    n = c.sc[7] ? 9 : 8;
    d = {c.d8, 8'($random(seed))};
    wr(`UABT_ADDR_OPTION, {c.ow, 7'h00});
    one_w <= c.ow;
    wr(`UABT_ADDR_POWER_AND_BAUD_CONTROL, c.pc);
    wr(`UABT_ADDR_RLD_LO, rl);
    wr(`UABT_ADDR_RLD_HI, 8'hFF);
    wr(`UABT_ADDR_CNT_LO, rl);
    wr(`UABT_ADDR_CNT_HI, 8'hFF);
    wr(`UABT_ADDR_ACTL, c.ac);
    if (!c.rx) begin
      wr(`UABT_ADDR_SCTL, {c.sc[7:4], c.d8, 3'b000});
      wr(`UABT_ADDR_SDATA, d[7:0]);
      peer.recv(per, n, got, okf);
      q.push_back(n == 9 ? d : {1'b0, d[7:0]});
      chk(16'(got), 16'(q.pop_front()));
      ok(okf);
      rd(`UABT_ADDR_SCTL, r);
      ok(r[1]);
    end else begin
      acc = c.sc[4] && !(c.sc[5] && (n == 9 ? !c.d8 : !c.stp));
      wr(`UABT_ADDR_SCTL, c.sc);
      peer.send(per, n, d, c.stp);
      repeat (4) @(posedge i_clock);
      rd(`UABT_ADDR_SCTL, r);
      chk(16'(r[0]), 16'(acc));
      if (acc) begin
        rd(`UABT_ADDR_SDATA, r2);
        chk(16'(r2), 16'(d[7:0]));
        if (n == 9 || !c.sc[5]) begin
          chk(16'(r[2]), 16'(n == 9 ? c.d8 : c.stp));
        end
      end
    end
    rd(`UABT_ADDR_ACTL, r);
    chk(16'(r[7]), 16'h0000);
    wr(`UABT_ADDR_SCTL, 8'h00);
    wr(`UABT_ADDR_ACTL, 8'h00);
  endtask

  task automatic trig();
    repeat (4) @(posedge i_clock);
    trg_pin <= 1'b0;
    repeat (10) @(posedge i_clock);
    trg_pin <= 1'b1;
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    logic [7:0] r;
    logic [7:0] r2;
    logic [7:0] b;
    logic p;
    int t;
    int n;
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], r);
      chk(16'(r), 16'h0000);
    end
    foreach (cs[i]) run_case(cs[i]);
    b = 8'($random(seed));
    wr(`UABT_ADDR_SCTL, 8'h00);
    wr(`UABT_ADDR_SDATA, b);
    n = 0;
    t = 0;
    p = 1'b1;
    while (n < 8 && t < 40) begin
      @(posedge i_clock);
      t++;
      if (sclk === 1'b1 && p === 1'b0) begin
        r[n] = txd;
        n++;
      end
      p = sclk;
    end
    ok(t <= 22 && n == 8);
    chk(16'(r), 16'(b));
    rd(`UABT_ADDR_SCTL, r);
    ok(r[1]);
    wr(`UABT_ADDR_SCTL, 8'h10);
    repeat (24) @(posedge i_clock);
    rd(`UABT_ADDR_SCTL, r);
    ok(r[0]);
    rd(`UABT_ADDR_SDATA, r);
    chk(16'(r), 16'h00FF);
    wr(`UABT_ADDR_CNT_LO, 8'h00);
    wr(`UABT_ADDR_CNT_HI, 8'h00);
    wr(`UABT_ADDR_ACTL, 8'h04);
    repeat (100) @(posedge i_clock);
    wr(`UABT_ADDR_ACTL, 8'h00);
    rd(`UABT_ADDR_CNT_LO, r);
    ok(r >= 8'h31 && r <= 8'h35);
    repeat (20) @(posedge i_clock);
    rd(`UABT_ADDR_CNT_LO, r2);
    chk(16'(r2), 16'(r));
    wr(`UABT_ADDR_RLD_LO, 8'h34);
    wr(`UABT_ADDR_RLD_HI, 8'h12);
    wr(`UABT_ADDR_CNT_LO, 8'hF0);
    wr(`UABT_ADDR_CNT_HI, 8'hFF);
    wr(`UABT_ADDR_ACTL, 8'h04);
    repeat (40) @(posedge i_clock);
    rd(`UABT_ADDR_ACTL, r);
    ok(r[7]);
    rd(`UABT_ADDR_CNT_HI, r);
    chk(16'(r), 16'h0012);
    wr(`UABT_ADDR_ACTL, 8'h00);
    rd(`UABT_ADDR_ACTL, r);
    chk(16'(r), 16'h0000);
    wr(`UABT_ADDR_CNT_LO, 8'h00);
    wr(`UABT_ADDR_CNT_HI, 8'h00);
    wr(`UABT_ADDR_ACTL, 8'h06);
    repeat (5) begin
      cnt_pin <= 1'b0;
      repeat (6) @(posedge i_clock);
      cnt_pin <= 1'b1;
      repeat (6) @(posedge i_clock);
    end
    rd(`UABT_ADDR_CNT_LO, r);
    chk(16'(r), 16'h0005);
    wr(`UABT_ADDR_CNT_LO, 8'h00);
    wr(`UABT_ADDR_ACTL, 8'h0D);
    repeat (36) @(posedge i_clock);
    trig();
    rd(`UABT_ADDR_ACTL, r);
    chk(16'(r[7:6]), 16'h0001);
    rd(`UABT_ADDR_RLD_LO, r);
    rd(`UABT_ADDR_CNT_LO, r2);
    ok(r >= 8'h14 && r <= 8'h1A && r2 > r + 2);
    wr(`UABT_ADDR_RLD_LO, 8'h00);
    wr(`UABT_ADDR_RLD_HI, 8'h80);
    wr(`UABT_ADDR_ACTL, 8'h0C);
    trig();
    rd(`UABT_ADDR_CNT_HI, r);
    chk(16'(r), 16'h0080);
    wr(`UABT_ADDR_CNT_HI, 8'h00);
    wr(`UABT_ADDR_ACTL, 8'h2C);
    trig();
    rd(`UABT_ADDR_CNT_HI, r);
    chk(16'(r), 16'h0000);
    rd(`UABT_ADDR_ACTL, r);
    chk(16'(r[6]), 16'h0000);
    test_done();
  end

  initial begin
    #200000;
    bad_count++;
    test_done();
  end
endmodule
